/* File: hdl/rsc_defines.vh */
// rsc_defines.vh: constants of the reset source controller
// assumes inclusion by bare name from hdl/ design files
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

// register addresses on the plain register port
`define RSC_ADDR_GUARD      4'h0
`define RSC_ADDR_FLAGS      4'h1
`define RSC_ADDR_UVCFG      4'h2
`define RSC_ADDR_IAP        4'h3
`define RSC_ADDR_WDCTRL     4'h4
`define RSC_ADDR_STATUS     4'h5

// guard register codes
`define RSC_GUARD_IO        8'h55
`define RSC_GUARD_RST       8'haa
`define RSC_GUARD_POR       8'h55

// undervoltage threshold codes
`define RSC_UV_1V7          8'h66
`define RSC_UV_1V9          8'h55
`define RSC_UV_2V55         8'h33
`define RSC_UV_3V15         8'h99
`define RSC_UV_3V8          8'haa
`define RSC_UV_OFF          8'hf0
`define RSC_UV_POR          8'h66

// watchdog control enable field codes
`define RSC_WD_OFF          5'h15
`define RSC_WD_ON           5'h0a
`define RSC_WD_POR          8'h53

// in-application-programming reset command
`define RSC_IAP_RESET       8'h55

// reset cause flag bit positions
`define RSC_FLAG_GUARD      3
`define RSC_FLAG_UVEVT      2
`define RSC_FLAG_UVSEL      1
`define RSC_FLAG_WDCTRL     0

// timing counts in cycles of sys_clk (25 MHz)
`define RSC_CLK_MHZ         25
`define RSC_SOFT_DELAY_NS   1000
`define RSC_SOFT_CYC        ((`RSC_SOFT_DELAY_NS * `RSC_CLK_MHZ + 999) / 1000)
`define RSC_HOLD_DELAY_NS   2000
`define RSC_HOLD_CYC        ((`RSC_HOLD_DELAY_NS * `RSC_CLK_MHZ + 999) / 1000)
`define RSC_UVF_TIME_NS     400
`define RSC_UVF_CYC         ((`RSC_UVF_TIME_NS * `RSC_CLK_MHZ) / 1000)

// reset pulse width to the core
`define RSC_PULSE_CYC       8'h04

`endif

/* File: hdl/rsc_reset_ctrl.v */
// rsc_reset_ctrl.v: reset source controller of a small microcontroller
// assumes synchronous inputs, a plain register port and an external
// supply monitor and reset pin network outside the block
//
// Contract
// - guard 55h selects I/O, AAh reset, else delayed reset
// - guard register powers up as 55h
// - invalid guard value sets flag bit 3
// - every reset restores guard except watchdog warm reset
// - reset-pin selection overrides other pin sharing
// - low reset pin resets device, pc cleared
// - hold delay after pin release, operation inhibited
// - guard fault flag cleared only by software
// - flag bits 7 to 4 read zero
// - undervoltage reset off in sleep and idle
// - undervoltage must outlast filter time
// - valid undervoltage reset sets flag bit 2
// - threshold codes decode, f0h disables
// - undefined threshold code: delayed reset, restore value
// - undefined threshold code sets flag bit 1
// - undervoltage config powers up as 66h
// - genuine undervoltage reset keeps config contents
// - undervoltage flags cleared only by software
// - writing 55h to iap command resets device
// - normal watchdog timeout sets expired flag
// - sleep watchdog timeout: pc, sp, expired, powerdown
// - invalid watchdog control sets flag bit 0
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "rsc_defines.vh"

module rsc_reset_ctrl #(
	parameter SOFT_CYC = `RSC_SOFT_CYC, // soft-fault delay
	parameter HOLD_CYC = `RSC_HOLD_CYC, // startup hold delay
	parameter UVF_CYC  = `RSC_UVF_CYC   // undervoltage filter time
) (
	// clock and reset
	input  wire       sys_clk,
	input  wire       nrst,
	// register port
	input  wire [3:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	// reset pin and supply monitor
	input  wire       external_rst_pin,
	input  wire       supply_low,
	// core state and watchdog
	input  wire       sleep_idle,
	input  wire       wdt_timeout,
	// outputs to the core
	output reg        core_reset,
	output reg        core_run,
	output reg        pc_sp_clear,
	output reg        pin_is_reset,
	output reg  [2:0] uv_level,
	output reg        uv_active
);

	////////////////////////////////////////////////////////////////////
	// local states and helpers

	localparam [3:0] ST_RUN  = 4'b0001; // normal operation
	localparam [3:0] ST_RST  = 4'b0010; // reset pulse to core
	localparam [3:0] ST_PIN  = 4'b0100; // pin held low
	localparam [3:0] ST_HOLD = 4'b1000; // startup hold

	// threshold decode: 0 invalid, 1..5 level, 6 disabled
	function [2:0] uv_decode;
		input [7:0] code;
		begin
			case (code)
				`RSC_UV_1V7:  uv_decode = 3'h1;
				`RSC_UV_1V9:  uv_decode = 3'h2;
				`RSC_UV_2V55: uv_decode = 3'h3;
				`RSC_UV_3V15: uv_decode = 3'h4;
				`RSC_UV_3V8:  uv_decode = 3'h5;
				`RSC_UV_OFF:  uv_decode = 3'h6;
				default:      uv_decode = 3'h0;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// registers

	reg  [7:0]  guard_q;      // pin function guard
	reg  [3:0]  flags_q;      // reset cause flags
	reg  [7:0]  uvcfg_q;      // undervoltage config
	reg  [7:0]  wdctrl_q;     // watchdog control
	reg         wdt_exp_q;    // watchdog expired flag
	reg         pdown_q;      // powerdown flag
	reg  [3:0]  state_q;      // sequencer state
	reg  [15:0] cnt_q;        // sequencer counter
	reg  [15:0] soft_cnt_q;   // soft-fault delay counter
	reg  [15:0] uv_cnt_q;     // undervoltage filter counter
	reg         warm_q;       // pending reset is watchdog warm
	reg         uvhold_q;     // pending reset keeps uv config

	wire        wr_guard = reg_wr && (reg_addr == `RSC_ADDR_GUARD);
	wire        wr_flags = reg_wr && (reg_addr == `RSC_ADDR_FLAGS);
	wire        wr_uv    = reg_wr && (reg_addr == `RSC_ADDR_UVCFG);
	wire        wr_wd    = reg_wr && (reg_addr == `RSC_ADDR_WDCTRL);
	wire        wr_stat  = reg_wr && (reg_addr == `RSC_ADDR_STATUS);
	wire        iap_hit  = reg_wr && (reg_addr == `RSC_ADDR_IAP)
	                       && (reg_wdata == `RSC_IAP_RESET);

	// fault decode on stored values
	wire guard_bad = (guard_q != `RSC_GUARD_IO) && (guard_q != `RSC_GUARD_RST);
	wire uv_bad    = (uv_decode(uvcfg_q) == 3'h0);
	wire wd_bad    = (wdctrl_q[7:3] != `RSC_WD_OFF) && (wdctrl_q[7:3] != `RSC_WD_ON);
	wire soft_bad  = guard_bad || uv_bad || wd_bad;
	wire soft_fire = soft_bad && (soft_cnt_q >= SOFT_CYC[15:0] - 16'h0001);

	// pin function: reset use wins over every other pin sharing
	wire pin_rst = (guard_q == `RSC_GUARD_RST);
	wire pin_low = pin_rst && !external_rst_pin;

	// undervoltage enabled outside sleep and idle only
	wire uv_en   = !uv_bad && (uv_decode(uvcfg_q) != 3'h6) && !sleep_idle;
	wire uv_fire = uv_en && supply_low && (uv_cnt_q >= UVF_CYC[15:0]);

	wire running  = (state_q == ST_RUN);
	// last hold cycle with the pin released: sequence ends, guarded
	// registers not kept by the pending reset return to their power-up values at this edge
	wire seq_done = (state_q == ST_HOLD) && !pin_low && (cnt_q >= HOLD_CYC[15:0] - 16'h0001);
	wire wdt_norm = running && wdt_timeout && !sleep_idle;
	wire wdt_slp  = running && wdt_timeout && sleep_idle;
	wire any_rst  = running && (soft_fire || uv_fire || iap_hit || wdt_norm || pin_low);

	////////////////////////////////////////////////////////////////////
	// soft-fault delay and undervoltage filter counters

	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			soft_cnt_q <= 16'h0000;
			uv_cnt_q   <= 16'h0000;
		end
		else
		begin
			// delay runs while a guarded value is invalid
			if (soft_bad && running)
				soft_cnt_q <= soft_fire ? soft_cnt_q : soft_cnt_q + 16'h0001;
			else
				soft_cnt_q <= 16'h0000;
			// short low-supply episodes restart the filter
			if (uv_en && supply_low && running)
				uv_cnt_q <= uv_fire ? uv_cnt_q : uv_cnt_q + 16'h0001;
			else
				uv_cnt_q <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// reset sequencer: pulse, pin wait, startup hold

	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q  <= ST_HOLD;
			cnt_q    <= 16'h0000;
			warm_q   <= 1'b0;
			uvhold_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				ST_RUN:
				begin
					// watch every source of reset
					if (any_rst)
					begin
						state_q  <= ST_RST;
						cnt_q    <= 16'h0000;
						warm_q   <= wdt_norm && !pin_low && !soft_fire && !iap_hit && !uv_fire;
						uvhold_q <= uv_fire && !soft_fire;
					end
				end
				ST_RST:
				begin
					// fixed-width pulse, then wait for the pin
					cnt_q    <= cnt_q + 16'h0001;
					// cause bits stand until the restore at the end
					if (cnt_q >= {8'h00, `RSC_PULSE_CYC})
					begin
						state_q <= ST_PIN;
						cnt_q   <= 16'h0000;
					end
				end
				ST_PIN:
				begin
					// operation inhibited while the pin stays low
					if (!pin_low)
					begin
						state_q <= ST_HOLD;
						cnt_q   <= 16'h0000;
					end
				end
				ST_HOLD:
				begin
					// extra delay after release
					if (pin_low)
						state_q <= ST_PIN;
					else if (seq_done)
					begin
						state_q  <= ST_RUN;
						warm_q   <= 1'b0;
						uvhold_q <= 1'b0;
					end
					else
						cnt_q <= cnt_q + 16'h0001;
				end
				default:
				begin
					state_q <= ST_HOLD;
					cnt_q   <= 16'h0000;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// guard, config and watchdog control registers

	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			guard_q  <= `RSC_GUARD_POR;
			uvcfg_q  <= `RSC_UV_POR;
			wdctrl_q <= `RSC_WD_POR;
		end
		else if (seq_done)
		begin
			// restore at the end of the sequence, so a reset pin
			// selection stays in force while the pin is held low
			// restore guard on all but the warm watchdog reset
			if (!warm_q)
				guard_q <= `RSC_GUARD_POR;
			// undervoltage config kept after a genuine event or a warm watchdog reset
			if (!uvhold_q && !warm_q)
				uvcfg_q <= `RSC_UV_POR;
			if (!warm_q)
				wdctrl_q <= `RSC_WD_POR;
		end
		else if (running)
		begin
			if (wr_guard)
				guard_q <= reg_wdata;
			if (wr_uv)
				uvcfg_q <= reg_wdata;
			if (wr_wd)
				wdctrl_q <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// sticky cause flags: hardware set beats software clear

	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			flags_q   <= 4'h0;
			wdt_exp_q <= 1'b0;
			pdown_q   <= 1'b0;
		end
		else
		begin
			// software writes, hardware sets win
			if (wr_flags)
				flags_q <= reg_wdata[3:0];
			if (running && soft_fire && guard_bad)
				flags_q[`RSC_FLAG_GUARD] <= 1'b1;
			if (running && uv_fire && !soft_fire)
				flags_q[`RSC_FLAG_UVEVT] <= 1'b1;
			if (running && soft_fire && uv_bad)
				flags_q[`RSC_FLAG_UVSEL] <= 1'b1;
			if (running && soft_fire && wd_bad)
				flags_q[`RSC_FLAG_WDCTRL] <= 1'b1;
			// status flags: set by watchdog timeouts
			if (wr_stat)
			begin
				wdt_exp_q <= reg_wdata[1];
				pdown_q   <= reg_wdata[0];
			end
			if (wdt_norm)
				wdt_exp_q <= 1'b1;
			if (wdt_slp)
			begin
				wdt_exp_q <= 1'b1;
				pdown_q   <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs and read data

	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			reg_rdata    <= 8'h00;
			core_reset   <= 1'b1;
			core_run     <= 1'b0;
			pc_sp_clear  <= 1'b0;
			pin_is_reset <= 1'b0;
			uv_level     <= 3'h0;
			uv_active    <= 1'b0;
		end
		else
		begin
			// core held in reset until back to run; pc cleared on a sleep watchdog timeout
			core_reset   <= (state_q != ST_RUN) || any_rst;
			core_run     <= running && !any_rst;
			pc_sp_clear  <= wdt_slp;
			pin_is_reset <= pin_rst;
			uv_level     <= uv_decode(uvcfg_q);
			uv_active    <= uv_en;
			// read data valid the cycle after the read strobe
			if (reg_rd)
			begin
				case (reg_addr)
					`RSC_ADDR_GUARD:  reg_rdata <= guard_q;
					`RSC_ADDR_FLAGS:  reg_rdata <= {4'h0, flags_q};
					`RSC_ADDR_UVCFG:  reg_rdata <= uvcfg_q;
					`RSC_ADDR_WDCTRL: reg_rdata <= wdctrl_q;
					`RSC_ADDR_STATUS: reg_rdata <= {6'h00, wdt_exp_q, pdown_q};
					default:          reg_rdata <= 8'h00;
				endcase
			end
			else
				reg_rdata <= 8'h00;
		end
	end

endmodule // rsc_reset_ctrl

/* File: test/rsc_far_side.sv */
// rsc_far_side.sv: external reset network and supply monitor model
// assumes the bench calls its tasks at a rising edge of sys_clk
`timescale 1ns/1ps
module rsc_far_side (
	// clock
	input  wire sys_clk,
	// reset pin network and supply monitor
	output reg  external_rst_pin,
	output reg  supply_low
);
	// pull-up idles the pin high, supply starts healthy
	initial external_rst_pin = 1'b1;
	initial supply_low = 1'b0;
	// pull the pin low for n cycles
	task press(input int n);
		@(posedge sys_clk);
		external_rst_pin <= 1'b0;
		repeat (n) @(posedge sys_clk);
		external_rst_pin <= 1'b1;
	endtask
	// report a low supply for n cycles
	task dip(input int n);
		@(posedge sys_clk);
		supply_low <= 1'b1;
		repeat (n) @(posedge sys_clk);
		supply_low <= 1'b0;
	endtask
endmodule // rsc_far_side

/* File: test/rsc_reset_ctrl_props.sv */
// rsc_reset_ctrl_props.sv: port assertions of the reset source controller
// assumes one clock domain and the asynchronous active-low reset nrst
`timescale 1ns/1ps
module rsc_props #(
	parameter HOLD_CYC = 50 // startup hold delay in cycles
) (
	// clock and reset
	input wire       sys_clk,
	input wire       nrst,
	// register port
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	// pin and core state
	input wire       external_rst_pin,
	input wire       sleep_idle,
	input wire       wdt_timeout,
	// outputs to the core
	input wire       core_reset,
	input wire       core_run,
	input wire       pc_sp_clear,
	input wire       pin_is_reset,
	input wire       uv_active
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////
	reg [7:0] low_q; // cycles spent with operation inhibited
	// count the inhibited stretch, cleared while running
	always @(posedge sys_clk or negedge nrst)
		if (!nrst)
			low_q <= 8'h00;
		else if (core_run)
			low_q <= 8'h00;
		else if (low_q != 8'hff)
			low_q <= low_q + 8'h01;
	////////////////////////////////////////////////////////////////////////
	property p_iap;
		core_run && reg_wr && reg_addr == 4'h3 && reg_wdata == 8'h55 |=> core_reset && !core_run;
	endproperty
	a_iap: assert property (p_iap) else $error("command reset missing");
	property p_pin;
		core_run && !external_rst_pin ##1 pin_is_reset |-> core_reset;
	endproperty
	a_pin: assert property (p_pin) else $error("pin reset missing");
	property p_hold;
		$rose(core_run) |-> low_q >= HOLD_CYC;
	endproperty
	a_hold: assert property (p_hold) else $error("run resumed early");
	property p_soft;
		core_run && reg_wr && reg_addr == 4'h0 && reg_wdata != 8'h55 && reg_wdata != 8'haa
			|-> ##[1:300] core_reset;
	endproperty
	a_soft: assert property (p_soft) else $error("guard fault reset missing");
	property p_sel;
		core_run && reg_wr && reg_addr == 4'h0 && reg_wdata == 8'haa |-> ##[1:2] pin_is_reset;
	endproperty
	a_sel: assert property (p_sel) else $error("pin not given to reset");
	property p_wdslp;
		core_run && wdt_timeout && sleep_idle |=> pc_sp_clear && !core_reset;
	endproperty
	a_wdslp: assert property (p_wdslp) else $error("sleep timeout wrong");
	property p_wdrun;
		core_run && wdt_timeout && !sleep_idle |=> core_reset;
	endproperty
	a_wdrun: assert property (p_wdrun) else $error("timeout reset missing");
	property p_uvslp;
		sleep_idle ##1 sleep_idle |-> !uv_active;
	endproperty
	a_uvslp: assert property (p_uvslp) else $error("undervoltage armed in sleep");
endmodule // rsc_props
bind rsc_reset_ctrl rsc_props #(.HOLD_CYC(HOLD_CYC)) u_props (.sys_clk, .nrst, .reg_addr,
	.reg_wdata, .reg_wr, .external_rst_pin, .sleep_idle, .wdt_timeout, .core_reset,
	.core_run, .pc_sp_clear, .pin_is_reset, .uv_active);

/* File: test/tb_rsc_reset_ctrl.sv */
// tb_rsc_reset_ctrl.sv: self-checking bench of the reset source controller
// assumes rsc_far_side for the pin network and the supply monitor
`timescale 1ns/1ps
module tb_rsc_reset_ctrl;
	localparam HC = 4; // short startup hold
	localparam UC = 3; // short undervoltage filter
	reg        sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	reg        sleep_idle = 1'b0, wdt_timeout = 1'b0;
	reg  [3:0] reg_addr = 4'h0;
	reg  [7:0] reg_wdata = 8'h00;
	wire [7:0] reg_rdata;
	wire [2:0] uv_level;
	wire       external_rst_pin, supply_low, core_reset, core_run;
	wire       pc_sp_clear, pin_is_reset, uv_active;
	int        num_errors = 0, samples_checked = 0, i;
	logic [7:0] uvc [0:5] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0}; // decode order
	always #20 sys_clk = ~sys_clk;
	rsc_reset_ctrl #(.SOFT_CYC(3), .HOLD_CYC(HC), .UVF_CYC(UC)) dut (.sys_clk, .nrst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .external_rst_pin, .supply_low, .sleep_idle,
		.wdt_timeout, .core_reset, .core_run, .pc_sp_clear, .pin_is_reset, .uv_level, .uv_active);
	rsc_far_side u_far (.sys_clk, .external_rst_pin, .supply_low);
	////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task after(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", reg_rdata, exp);
	endtask
	// see a reset, then wait for normal operation
	task recover;
		for (i = 0; i < 50 && core_reset !== 1'b1; i++) after(1);
		chk("core_reset", {7'h0, core_reset}, 8'h01);
		for (i = 0; i < 200 && core_run !== 1'b1; i++) after(1);
		chk("core_run", {7'h0, core_run}, 8'h01);
	endtask
	task pulse_wd(input logic s);
		@(posedge sys_clk);
		sleep_idle <= s;
		wdt_timeout <= 1'b1;
		@(posedge sys_clk);
		wdt_timeout <= 1'b0;
		sleep_idle <= 1'b0;
		#1 chk("wd_effect", {6'h0, pc_sp_clear, core_reset}, s ? 8'h02 : 8'h01);
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_por;
		rd(4'h0, 8'h55);
		rd(4'h2, 8'h66);
		rd(4'h1, 8'h00);
		rd(4'h7, 8'h00);
	endtask
	task t_iap;
		wr(4'h0, 8'haa);
		wr(4'h3, 8'h55);
		#1 chk("core_reset", {7'h0, core_reset}, 8'h01);
		recover;
		rd(4'h0, 8'h55);
	endtask
	task t_pin;
		wr(4'h0, 8'haa);
		after(2);
		chk("pin_is_reset", {7'h0, pin_is_reset}, 8'h01);
		u_far.press(20);
		after(HC - 1);
		chk("core_run", {7'h0, core_run}, 8'h00);
		recover;
		rd(4'h0, 8'h55);
	endtask
	task t_guard;
		wr(4'h0, 8'h12);
		recover;
		rd(4'h1, 8'h08);
		rd(4'h0, 8'h55);
		wr(4'h1, 8'hff);
		rd(4'h1, 8'h0f);
		wr(4'h1, 8'h00);
		rd(4'h1, 8'h00);
	endtask
	task t_uv;
		for (int k = 0; k < 6; k++)
		begin
			wr(4'h2, uvc[k]);
			after(2);
			chk("uv_level", {5'h0, uv_level}, k[7:0] + 8'h01);
		end
		wr(4'h2, 8'h99);
		sleep_idle <= 1'b1;
		after(2);
		chk("uv_active", {7'h0, uv_active}, 8'h00);
		@(posedge sys_clk);
		sleep_idle <= 1'b0;
		u_far.dip(UC);
		after(2);
		chk("core_reset", {7'h0, core_reset}, 8'h00);
		u_far.dip(UC + 3);
		recover;
		rd(4'h1, 8'h04);
		rd(4'h2, 8'h99);
		wr(4'h1, 8'h00);
		wr(4'h2, 8'h11);
		recover;
		rd(4'h1, 8'h02);
		rd(4'h2, 8'h66);
		wr(4'h1, 8'h00);
	endtask
	task t_wd;
		pulse_wd(1'b1);
		rd(4'h5, 8'h03);
		wr(4'h5, 8'h00);
		wr(4'h0, 8'haa);
		pulse_wd(1'b0);
		recover;
		rd(4'h5, 8'h02);
		rd(4'h0, 8'haa);
		wr(4'h4, 8'h00);
		recover;
		rd(4'h1, 8'h01);
	endtask
	task complete_run;
		if (num_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		recover;
		t_por;
		t_iap;
		t_pin;
		t_guard;
		t_uv;
		t_wd;
		complete_run;
	end
	// cut a hang short after some 10000 cycles
	initial
	begin
		#400000;
		num_errors++;
		complete_run;
	end
endmodule // tb_rsc_reset_ctrl
